// file: inc/rgc_pkg.sv
// shared constants and types of the receiver gain control loops
package rgc_pkg;

    // ----------------------------------------
    // register byte addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SLOW_GAIN = 8'h04;
    localparam logic [7:0] ADDR_REQ_LEVEL = 8'h08;
    localparam logic [7:0] ADDR_SLOW_PERIOD = 8'h0c;
    localparam logic [7:0] ADDR_FA_CFG = 8'h10;
    localparam logic [7:0] ADDR_FD_CFG = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_PEAKS = 8'h1c;

    // ----------------------------------------
    // field widths and positions
    // ----------------------------------------
    localparam int MANT_W = 6;
    localparam int EXPO_W = 3;
    localparam int REQ_W = 8;
    localparam int PER_W = 8;
    localparam int STEP_W = 5;
    localparam int CNT_W = 5;
    localparam int SPB_W = 10;
    localparam int EXPO_POS = 8;
    localparam int FA_CNT_POS = 8;
    localparam int FD_STEP_POS = 16;
    localparam int FD_PER_POS = 24;
    localparam int ST_FA_POS = 16;
    localparam int ST_FD_POS = 17;
    localparam int PK_FD_POS = 16;

    // ----------------------------------------
    // level arithmetic: one lsb is 6.02/64 dB
    // ----------------------------------------
    localparam int DB_PER_OCTAVE = 64;
    localparam int FRAC_DB_BITS = 6;
    localparam int MANT_DIV_LOG2 = 8;
    localparam int FRAC_BITS = 16;
    localparam logic [3:0] SHIFT_BASE = 4'h8;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [MANT_W-1:0] RST_MANT = 6'h10;
    localparam logic [EXPO_W-1:0] RST_EXPO = 3'h2;
    localparam logic [REQ_W-1:0] RST_REQ_LEVEL = 8'h40;
    localparam logic [PER_W-1:0] RST_SLOW_PERIOD = 8'h18;
    localparam logic [STEP_W-1:0] RST_FA_STEP = 5'h04;
    localparam logic [CNT_W-1:0] RST_FA_COUNT = 5'h04;
    localparam logic [SPB_W-1:0] RST_SPB_THR = 10'h1a9;
    localparam logic [STEP_W-1:0] RST_FD_STEP = 5'h01;
    localparam logic [PER_W-1:0] RST_FD_PERIOD = 8'h04;

    typedef struct packed {
        logic enable;
        logic [MANT_W-1:0] mant;
        logic [EXPO_W-1:0] expo;
        logic [REQ_W-1:0] req_level;
        logic [PER_W-1:0] slow_period;
        logic [STEP_W-1:0] fa_step;
        logic [CNT_W-1:0] fa_count;
        logic [SPB_W-1:0] spb_thr;
        logic [STEP_W-1:0] fd_step;
        logic [PER_W-1:0] fd_period;
    } rgc_cfg_type;

    typedef enum logic [1:0] {
        RGC_HOLD,
        RGC_SLOW,
        RGC_DECAY,
        RGC_ATTACK
    } rgc_src_type;

endpackage

// file: src/rgc_peak_detect.sv
// peak of max(|i|,|q|) over a sample period, reported as attenuation below full scale
`timescale 1ns/1ps
module rgc_peak_detect #(
    parameter int W = 16,
    parameter int PW = 8,
    parameter int LW = 10
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic sample_valid,
    input wire logic signed [W-1:0] sample_i,
    input wire logic signed [W-1:0] sample_q,
    input wire logic [PW-1:0] period,
    output logic [LW-1:0] peak_atten,
    output logic peak_done
);

    logic [W-1:0] abs_i;
    logic [W-1:0] abs_q;
    logic [W-1:0] mag;
    logic [W-1:0] hold;
    logic [W-1:0] best;
    logic [PW-1:0] cnt;
    logic last;

    // log2 as octave*64 plus six mantissa bits, subtracted from full scale
    function automatic logic [LW-1:0] to_atten(input logic [W-1:0] m);
        logic [W-1:0] norm;
        int msb;
        logic [LW-1:0] level;
        msb = 0;
        for (int k = 0; k < W; k++) begin
            if (m[k]) begin
                msb = k;
            end
        end
        norm = m << (W - 1 - msb);
        level = LW'(msb * rgc_pkg::DB_PER_OCTAVE)
              + LW'(norm[W-2 -: rgc_pkg::FRAC_DB_BITS]);
        return LW'((W - 1) * rgc_pkg::DB_PER_OCTAVE) - level;
    endfunction

    assign abs_i = sample_i[W-1] ? W'(-sample_i) : sample_i;
    assign abs_q = sample_q[W-1] ? W'(-sample_q) : sample_q;
    assign mag = (abs_i > abs_q) ? abs_i : abs_q;
    assign best = (cnt == '0 || mag > hold) ? mag : hold;
    assign last = ({1'b0, cnt} + 1'b1) >= {1'b0, period};

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cnt <= '0;
            hold <= '0;
            peak_done <= 1'b0;
            peak_atten <= '0;
        end else begin
            peak_done <= 1'b0;
            if (sample_valid) begin
                hold <= best;
                if (last) begin
                    cnt <= '0;
                    peak_done <= 1'b1;
                    peak_atten <= to_atten(best);
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    end

endmodule

// file: src/rgc_slow_step.sv
// slow loop gain step: error times mantissa/256 times 2^-exponent, in fixed point
`timescale 1ns/1ps
module rgc_slow_step #(
    parameter int EW = 11,
    parameter int AW = 27
) (
    input wire logic signed [EW-1:0] err,
    input wire logic [rgc_pkg::MANT_W-1:0] mant,
    input wire logic [rgc_pkg::EXPO_W-1:0] expo,
    output logic signed [AW-1:0] delta
);

    logic signed [EW+rgc_pkg::MANT_W:0] prod;
    logic [3:0] shift;

    // mantissa over 256, scaled by 2^-exponent
    assign prod = err * $signed({1'b0, mant});
    assign shift = rgc_pkg::SHIFT_BASE - {1'b0, expo};
    // larger loop gain gives a larger step
    assign delta = AW'(prod) <<< shift;

endmodule

// file: src/rgc_agc.sv
// three-loop automatic gain control steering the front-end amplifier
//
// Functional notes
// - slow loop gain is mantissa/256 times 2^-exponent; mantissa 0..63, exponent 0..7
// - bigger loop gain makes the slow loop move faster, smaller slower
// - slow loop steers level toward requested level, 0 to -24 dBFS, 0.094 dB lsb
// - requested level resets to -6.02 dBFS
// - slow peak detector takes dB of max |I|,|Q| over a programmable period
// - overdrive detector hands control to the attack loop, which lowers gain
// - attack step is 0 to 1.504 dB in 0.094 dB steps
// - attack count is 1..16; gain drops for count plus one cycles
// - decay loop raises gain below its threshold and overrides slow loop
// - decay threshold resets to -40 dBFS
// - decay step resets to 0.094 dB, decay peak period to four samples
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
module rgc_agc #(
    parameter int W = 16,
    parameter int GW = 10,
    parameter logic [GW-1:0] GAIN_INIT = 10'h100
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic sample_valid,
    input wire logic signed [W-1:0] sample_i,
    input wire logic signed [W-1:0] sample_q,
    input wire logic overdrive,
    output logic [GW-1:0] vga_gain,
    output logic gain_strobe
);

    localparam int LW = rgc_pkg::SPB_W;
    localparam int FB = rgc_pkg::FRAC_BITS;
    localparam int AW = GW + 1 + FB;
    localparam int EW = LW + 1;

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    rgc_pkg::rgc_cfg_type cfg;
    rgc_pkg::rgc_cfg_type next_cfg;

    wire wr_ctrl = reg_wr && reg_addr == rgc_pkg::ADDR_CTRL;
    wire wr_slow_gain = reg_wr && reg_addr == rgc_pkg::ADDR_SLOW_GAIN;
    wire wr_req = reg_wr && reg_addr == rgc_pkg::ADDR_REQ_LEVEL;
    wire wr_slow_per = reg_wr && reg_addr == rgc_pkg::ADDR_SLOW_PERIOD;
    wire wr_fa = reg_wr && reg_addr == rgc_pkg::ADDR_FA_CFG;
    wire wr_fd = reg_wr && reg_addr == rgc_pkg::ADDR_FD_CFG;

    wire [rgc_pkg::MANT_W-1:0] w_mant = reg_wdata[rgc_pkg::MANT_W-1:0];
    wire [rgc_pkg::EXPO_W-1:0] w_expo = reg_wdata[rgc_pkg::EXPO_POS +: rgc_pkg::EXPO_W];
    wire [rgc_pkg::STEP_W-1:0] w_step = reg_wdata[rgc_pkg::STEP_W-1:0];
    wire [rgc_pkg::CNT_W-1:0] w_fa_cnt = reg_wdata[rgc_pkg::FA_CNT_POS +: rgc_pkg::CNT_W];
    wire [rgc_pkg::STEP_W-1:0] w_fd_step = reg_wdata[rgc_pkg::FD_STEP_POS +: rgc_pkg::STEP_W];
    wire [rgc_pkg::PER_W-1:0] w_fd_per = reg_wdata[rgc_pkg::FD_PER_POS +: rgc_pkg::PER_W];

    always_comb begin
        next_cfg = cfg;
        if (wr_ctrl) begin
            next_cfg.enable = reg_wdata[0];
        end
        if (wr_slow_gain) begin
            next_cfg.mant = w_mant;
            next_cfg.expo = w_expo;
        end
        // requested level in 0.094 dB steps
        if (wr_req) begin
            next_cfg.req_level = reg_wdata[rgc_pkg::REQ_W-1:0];
        end
        if (wr_slow_per) begin
            next_cfg.slow_period = reg_wdata[rgc_pkg::PER_W-1:0];
        end
        // attack step capped at 1.504 dB
        if (wr_fa) begin
            next_cfg.fa_step = (w_step > 5'h10) ? 5'h10 : w_step;
            next_cfg.fa_count = (w_fa_cnt == '0) ? 5'h01 : (w_fa_cnt > 5'h10) ? 5'h10 : w_fa_cnt;
        end
        if (wr_fd) begin
            next_cfg.spb_thr = reg_wdata[LW-1:0];
            next_cfg.fd_step = w_fd_step;
            next_cfg.fd_period = w_fd_per;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cfg.enable <= 1'b1;
            cfg.mant <= rgc_pkg::RST_MANT;
            cfg.expo <= rgc_pkg::RST_EXPO;
            cfg.req_level <= rgc_pkg::RST_REQ_LEVEL;
            cfg.slow_period <= rgc_pkg::RST_SLOW_PERIOD;
            cfg.fa_step <= rgc_pkg::RST_FA_STEP;
            cfg.fa_count <= rgc_pkg::RST_FA_COUNT;
            cfg.spb_thr <= rgc_pkg::RST_SPB_THR;
            cfg.fd_step <= rgc_pkg::RST_FD_STEP;
            cfg.fd_period <= rgc_pkg::RST_FD_PERIOD;
        end else begin
            cfg <= next_cfg;
        end
    end

    // ----------------------------------------
    // peak detectors
    // ----------------------------------------
    logic [LW-1:0] slow_atten;
    logic slow_done;
    logic [LW-1:0] fd_atten;
    logic fd_done;

    // slow loop peak over its own period
    rgc_peak_detect #(.W(W), .PW(rgc_pkg::PER_W), .LW(LW)) u_slow_peak (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .sample_valid(sample_valid),
        .sample_i(sample_i),
        .sample_q(sample_q),
        .period(cfg.slow_period),
        .peak_atten(slow_atten),
        .peak_done(slow_done)
    );

    // wideband peak over the decay period
    rgc_peak_detect #(.W(W), .PW(rgc_pkg::PER_W), .LW(LW)) u_fd_peak (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .sample_valid(sample_valid),
        .sample_i(sample_i),
        .sample_q(sample_q),
        .period(cfg.fd_period),
        .peak_atten(fd_atten),
        .peak_done(fd_done)
    );

    // ----------------------------------------
    // slow loop step
    // ----------------------------------------
    logic signed [EW-1:0] slow_err;
    logic signed [AW-1:0] slow_delta;

    // positive error means the level sits below the requested level
    assign slow_err = $signed({1'b0, slow_atten})
                    - $signed({{(EW-rgc_pkg::REQ_W){1'b0}}, cfg.req_level});

    rgc_slow_step #(.EW(EW), .AW(AW)) u_slow_step (
        .err(slow_err),
        .mant(cfg.mant),
        .expo(cfg.expo),
        .delta(slow_delta)
    );

    // ----------------------------------------
    // overdrive attack and fade recovery loops
    // ----------------------------------------
    logic overdrive_prev;
    logic [rgc_pkg::CNT_W:0] fa_left;
    logic [rgc_pkg::CNT_W:0] next_fa_left;
    logic fd_active;
    logic next_fd_active;

    wire overdrive_rise = overdrive && !overdrive_prev;
    wire overdrive_attack_loop = fa_left != '0;
    wire fd_below = fd_atten > cfg.spb_thr;
    wire fd_step_req = fd_done && fd_below;

    // reload with count plus one on each crossing
    assign next_fa_left = overdrive_rise ? ({1'b0, cfg.fa_count} + 1'b1)
                        : overdrive_attack_loop ? fa_left - 1'b1 : fa_left;
    // decay holds control while the wideband level stays low
    assign next_fd_active = fd_done ? fd_below : fd_active;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            overdrive_prev <= 1'b0;
            fa_left <= '0;
            fd_active <= 1'b0;
        end else begin
            overdrive_prev <= overdrive;
            fa_left <= next_fa_left;
            fd_active <= next_fd_active;
        end
    end

    // ----------------------------------------
    // gain accumulator and loop arbitration
    // ----------------------------------------
    logic signed [AW-1:0] acc;
    logic signed [AW-1:0] next_acc;
    logic signed [AW-1:0] sel_delta;
    logic signed [AW:0] sum;
    rgc_pkg::rgc_src_type src;

    wire signed [AW-1:0] fa_delta =
        -$signed({{(AW-rgc_pkg::STEP_W-FB){1'b0}}, cfg.fa_step, {FB{1'b0}}});
    wire signed [AW-1:0] fd_delta =
        $signed({{(AW-rgc_pkg::STEP_W-FB){1'b0}}, cfg.fd_step, {FB{1'b0}}});
    wire signed [AW:0] gain_top = $signed({2'b00, {GW{1'b1}}, {FB{1'b0}}});

    // attack first, then decay, then the slow loop
    always_comb begin
        if (!cfg.enable) begin
            src = rgc_pkg::RGC_HOLD;
        // overdrive takes control from the slow loop
        end else if (overdrive_attack_loop) begin
            src = rgc_pkg::RGC_ATTACK;
        end else if (fd_step_req) begin
            src = rgc_pkg::RGC_DECAY;
        // slow loop muted while decay holds control
        end else if (slow_done && !fd_active) begin
            src = rgc_pkg::RGC_SLOW;
        end else begin
            src = rgc_pkg::RGC_HOLD;
        end
    end

    always_comb begin
        case (src)
            // attack lowers gain by its step
            rgc_pkg::RGC_ATTACK: sel_delta = fa_delta;
            // decay raises gain by its step
            rgc_pkg::RGC_DECAY: sel_delta = fd_delta;
            // slow step scales with loop gain
            rgc_pkg::RGC_SLOW: sel_delta = slow_delta;
            default: sel_delta = '0;
        endcase
    end

    assign sum = {acc[AW-1], acc} + {sel_delta[AW-1], sel_delta};

    // gain saturates at both ends rather than wrapping
    always_comb begin
        if (sum < 0) begin
            next_acc = '0;
        end else if (sum > gain_top) begin
            next_acc = AW'(gain_top);
        end else begin
            next_acc = AW'(sum);
        end
    end

    wire [GW-1:0] next_gain = next_acc[FB +: GW];

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            acc <= $signed({1'b0, GAIN_INIT, {FB{1'b0}}});
            vga_gain <= GAIN_INIT;
            gain_strobe <= 1'b0;
        end else begin
            acc <= next_acc;
            vga_gain <= next_gain;
            gain_strobe <= next_gain != vga_gain;
        end
    end

    // ----------------------------------------
    // register read port
    // ----------------------------------------
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        case (reg_addr)
            rgc_pkg::ADDR_CTRL: rd_mux[0] = cfg.enable;
            rgc_pkg::ADDR_SLOW_GAIN: begin
                rd_mux[rgc_pkg::MANT_W-1:0] = cfg.mant;
                rd_mux[rgc_pkg::EXPO_POS +: rgc_pkg::EXPO_W] = cfg.expo;
            end
            rgc_pkg::ADDR_REQ_LEVEL: rd_mux[rgc_pkg::REQ_W-1:0] = cfg.req_level;
            rgc_pkg::ADDR_SLOW_PERIOD: rd_mux[rgc_pkg::PER_W-1:0] = cfg.slow_period;
            rgc_pkg::ADDR_FA_CFG: begin
                rd_mux[rgc_pkg::STEP_W-1:0] = cfg.fa_step;
                rd_mux[rgc_pkg::FA_CNT_POS +: rgc_pkg::CNT_W] = cfg.fa_count;
            end
            rgc_pkg::ADDR_FD_CFG: begin
                rd_mux[LW-1:0] = cfg.spb_thr;
                rd_mux[rgc_pkg::FD_STEP_POS +: rgc_pkg::STEP_W] = cfg.fd_step;
                rd_mux[rgc_pkg::FD_PER_POS +: rgc_pkg::PER_W] = cfg.fd_period;
            end
            rgc_pkg::ADDR_STATUS: begin
                rd_mux[GW-1:0] = vga_gain;
                rd_mux[rgc_pkg::ST_FA_POS] = overdrive_attack_loop;
                rd_mux[rgc_pkg::ST_FD_POS] = fd_active;
            end
            rgc_pkg::ADDR_PEAKS: begin
                rd_mux[LW-1:0] = slow_atten;
                rd_mux[rgc_pkg::PK_FD_POS +: LW] = fd_atten;
            end
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : '0;
        end
    end

endmodule

// file: test/rgc_frontend_model.sv
// behavioural converter and overdrive comparator feeding the gain loops
`timescale 1ns/1ps
module rgc_frontend_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [15:0] amp,
    input wire logic od_cmd,
    output logic sample_valid,
    output logic signed [15:0] sample_i,
    output logic signed [15:0] sample_q,
    output logic overdrive
);
    logic ph;
    // ----------------------------------------
    // one sample a clock, peak swaps between i and q
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        ph <= rstn ? !ph : 1'h0;
        sample_valid <= rstn;
        sample_i <= ph ? -$signed(amp) : $signed(amp >> 1);
        sample_q <= ph ? $signed(amp >> 2) : -$signed(amp);
        overdrive <= od_cmd;
    end
endmodule

// file: test/rgc_agc_assertions.sv
// port checker for the gain control loops
`timescale 1ns/1ps
module rgc_agc_assertions #(
    parameter int W = 16,
    parameter int GW = 10,
    parameter logic [GW-1:0] GAIN_INIT = 10'h100
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic sample_valid,
    input wire logic signed [W-1:0] sample_i,
    input wire logic signed [W-1:0] sample_q,
    input wire logic overdrive,
    input wire logic [GW-1:0] vga_gain,
    input wire logic gain_strobe
);
    // ----------------------------------------
    // shadow of enable and attack settings
    // ----------------------------------------
    logic shadow_en;
    logic [4:0] shadow_step;
    logic [4:0] shadow_cnt;
    logic [4:0] attack_left;
    wire logic [4:0] cnt_w = reg_wdata[12:8];
    wire logic [4:0] next_cnt = cnt_w == 5'h00 ? 5'h01 : (cnt_w > 5'h10 ? 5'h10 : cnt_w);
    wire logic [4:0] next_step = reg_wdata[4:0] > 5'h10 ? 5'h10 : reg_wdata[4:0];
    wire logic wr_fa = reg_wr && reg_addr == rgc_pkg::ADDR_FA_CFG;
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            shadow_en <= 1'h1;
            shadow_step <= rgc_pkg::RST_FA_STEP;
            shadow_cnt <= rgc_pkg::RST_FA_COUNT;
            attack_left <= 5'h00;
        end else begin
            if (reg_wr && reg_addr == rgc_pkg::ADDR_CTRL) begin
                shadow_en <= reg_wdata[0];
            end
            if (wr_fa) begin
                shadow_step <= next_step;
                shadow_cnt <= next_cnt;
            end
            if ($rose(overdrive)) begin
                attack_left <= shadow_cnt + 5'h01;
            end else if (attack_left != 5'h00) begin
                attack_left <= attack_left - 5'h01;
            end
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    sequence s_read(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    sequence s_attack;
        attack_left != 5'h00 && shadow_en && vga_gain >= GW'(shadow_step);
    endsequence
    reset_gain_a: assert property ($rose(rstn) |-> vga_gain == GAIN_INIT && !gain_strobe)
        else $error("gain not at initial code after reset");
    read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read answer");
    unmapped_read_a: assert property (reg_rd && reg_addr > rgc_pkg::ADDR_PEAKS |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    status_gain_a: assert property (s_read(rgc_pkg::ADDR_STATUS) |=> reg_rdata[GW-1:0] == $past(vga_gain))
        else $error("status gain field wrong");
    strobe_match_a: assert property (gain_strobe == (vga_gain != $past(vga_gain)))
        else $error("gain strobe does not match gain change");
    attack_step_a: assert property (
        s_attack |=> vga_gain == $past(vga_gain) - GW'($past(shadow_step)))
        else $error("attack step wrong");
    attack_flag_a: assert property (
        s_read(rgc_pkg::ADDR_STATUS) ##0 attack_left != 5'h00 |=> reg_rdata[rgc_pkg::ST_FA_POS])
        else $error("attack flag not set");
    freeze_hold_a: assert property (!shadow_en |=> $stable(vga_gain))
        else $error("gain moved while disabled");
endmodule
bind rgc_agc rgc_agc_assertions #(.W(W), .GW(GW), .GAIN_INIT(GAIN_INIT)) chk (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .sample_valid(sample_valid),
    .sample_i(sample_i),
    .sample_q(sample_q),
    .overdrive(overdrive),
    .vga_gain(vga_gain),
    .gain_strobe(gain_strobe)
);

// file: test/rgc_agc_test.sv
// self-checking bench for the three-loop gain control
`timescale 1ns/1ps
module rgc_agc_test;
    logic clk_sys = 1'h0;
    logic rstn = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [31:0] reg_rdata;
    logic sample_valid;
    logic signed [15:0] sample_i;
    logic signed [15:0] sample_q;
    logic overdrive;
    logic [9:0] vga_gain;
    logic gain_strobe;
    logic [15:0] amp = 16'h4000;
    logic od_cmd = 1'h0;
    int error_cnt = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    logic [9:0] g;
    int n;

    always #5 clk_sys = !clk_sys;

    rgc_frontend_model fe_model (.clk_sys(clk_sys), .rstn(rstn), .amp(amp), .od_cmd(od_cmd),
        .sample_valid(sample_valid), .sample_i(sample_i), .sample_q(sample_q),
        .overdrive(overdrive));
    rgc_agc #(.W(16), .GW(10), .GAIN_INIT(10'h200)) DUT (.clk_sys(clk_sys), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_i(sample_i),
        .sample_q(sample_q), .overdrive(overdrive), .vga_gain(vga_gain),
        .gain_strobe(gain_strobe));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
    task automatic wait_strobe(input int lim, output int c);
        c = 0;
        do begin
            @(negedge clk_sys);
            c++;
        end while (gain_strobe !== 1'h1 && c < lim);
        check(gain_strobe, 1'h1);
    endtask
    task automatic pulse_od;
        @(posedge clk_sys);
        od_cmd <= 1'h1;
        @(posedge clk_sys);
        od_cmd <= 1'h0;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_defaults;
        logic [7:0] a [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20};
        logic [31:0] e [8] = '{32'h1, 32'h210, 32'h40, 32'h18, 32'h404, 32'h040101a9,
            32'h200, 32'h0};
        wr(rgc_pkg::ADDR_STATUS, 32'h3ff);
        wr(8'h20, 32'h5a);
        for (int k = 0; k < 8; k++) begin
            rd_reg(a[k], rd);
            check(rd, e[k]);
        end
    endtask
    task automatic t_slow;
        @(posedge clk_sys) amp <= 16'h2000;
        wait_strobe(60, n);
        g = vga_gain;
        repeat (3) begin
            wait_strobe(30, n);
            check(n, 24);
            check(vga_gain, g + 10'h001);
            g = vga_gain;
        end
        wr(rgc_pkg::ADDR_SLOW_GAIN, 32'h3f);
        repeat (4) wait_strobe(30, n);
        check(vga_gain, g + 10'h03f);
        wr(rgc_pkg::ADDR_SLOW_GAIN, 32'h0);
        @(negedge clk_sys);
        g = vga_gain;
        repeat (60) @(negedge clk_sys);
        check(vga_gain, g);
        wr(rgc_pkg::ADDR_SLOW_GAIN, 32'h210);
    endtask
    task automatic t_attack;
        logic [4:0] cnt [3] = '{5'h10, 5'h01, 5'h00};
        logic [4:0] stp [3] = '{5'h10, 5'h01, 5'h03};
        logic [9:0] drop [3] = '{10'h110, 10'h002, 10'h006};
        @(posedge clk_sys) amp <= 16'h4000;
        repeat (40) @(negedge clk_sys);
        for (int k = 0; k < 3; k++) begin
            wr(rgc_pkg::ADDR_FA_CFG, {19'h0, cnt[k], 3'h0, stp[k]});
            @(negedge clk_sys);
            g = vga_gain;
            pulse_od();
            rd_reg(rgc_pkg::ADDR_STATUS, rd);
            check(rd[rgc_pkg::ST_FA_POS], 1'h1);
            repeat (25) @(negedge clk_sys);
            check(vga_gain, g - drop[k]);
        end
    endtask
    task automatic t_decay;
        @(posedge clk_sys) amp <= 16'h015c;
        repeat (40) @(negedge clk_sys);
        rd_reg(rgc_pkg::ADDR_STATUS, rd);
        check(rd[rgc_pkg::ST_FD_POS], 1'h0);
        @(posedge clk_sys) amp <= 16'h0158;
        wr(rgc_pkg::ADDR_FD_CFG, 32'h040201a9);
        repeat (40) @(negedge clk_sys);
        rd_reg(rgc_pkg::ADDR_STATUS, rd);
        check(rd[rgc_pkg::ST_FD_POS], 1'h1);
        wait_strobe(10, n);
        g = vga_gain;
        repeat (3) begin
            wait_strobe(10, n);
            check(n, 4);
            check(vga_gain, g + 10'h002);
            g = vga_gain;
        end
        wr(rgc_pkg::ADDR_FA_CFG, 32'h00000401);
        pulse_od();
        repeat (2) @(negedge clk_sys);
        g = vga_gain;
        repeat (5) @(negedge clk_sys);
        // five attack cycles span a decay period, so a winning decay step would show
        check(vga_gain, g - 10'h005);
        repeat (20) @(negedge clk_sys);
    endtask
    task automatic t_freeze;
        wr(rgc_pkg::ADDR_CTRL, 32'h0);
        @(posedge clk_sys) amp <= 16'h2000;
        @(negedge clk_sys);
        g = vga_gain;
        repeat (60) @(negedge clk_sys);
        check(vga_gain, g);
        wr(rgc_pkg::ADDR_CTRL, 32'h1);
        wait_strobe(60, n);
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        rstn <= 1'h1;
        t_defaults();
        t_slow();
        t_attack();
        t_decay();
        t_freeze();
        end_sim();
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        error_cnt++;
        end_sim();
    end
endmodule
